// ### logic/tcc_cc_ctrl_regs.sv
// Purpose: cc detection control registers and their action sequencing
// Assumes: byte register port from the serial core, cc fsm outside this block
// Notes:   long timers are parameters so a bench can shorten them
module tcc_cc_ctrl_regs
  import tcc_pkg::*;
#(
  parameter int HOLD_CYCLES     = SINK_HOLD_CYCLES,
  parameter int DEBOUNCE_CYCLES = VBUS_LOSS_CYCLES,
  parameter int TW              = 27
)(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  input  wire logic       fsm_in_source,
  input  wire logic       fsm_in_unattached_src,
  input  wire logic       fsm_sink_attached,
  input  wire logic       fsm_vconn_want,
  input  wire logic       vbus_above_threshold,
  input  tcc_done_t       act_done,
  output tcc_req_t        act_req,
  output tcc_modes_t      modes,
  output logic            sink_exit_req,
  output logic            vconn_on,
  output logic [1:0]      adv_current_applied,
  output logic            adv_current_update,
  output logic [2:0]      pullup_current_override,
  output logic            pullup_forced,
  output logic [1:0]      low_power_current_select
);
  logic [5:0] act_q;
  logic [5:0] act_d;
  logic [7:0] en_q;
  logic [7:0] en_d;
  logic [7:0] cur_q;
  logic [7:0] cur_d;
  logic [1:0] adv_lat_q;
  logic [1:0] adv_lat_d;
  logic [1:0] adv_app_q;
  logic [1:0] adv_app_d;
  logic       upd_q;
  logic       upd_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       wr_act;
  logic       hold_run;
  logic       hold_done;
  logic       deb_done;
  tcc_act_t   owner;

  assign wr_act = reg_wr && (reg_addr == ADDR_ACTION);

  // one action to the fsm at a time, except both resets together; resets first
  always_comb
  begin
    if (act_q[B_RST_SRC] || act_q[B_RST_SNK])
      owner = ACT_RESET;
    else if (act_q[B_FORCE_ERR])
      owner = ACT_ERROR;
    else if (act_q[B_VCN_SWAP])
      owner = ACT_SWAP;
    else
      owner = ACT_IDLE;
  end

  always_comb
  begin
    act_req = '0;
    case (owner)
      ACT_RESET:
      begin
        act_req.reset_to_source = act_q[B_RST_SRC];
        act_req.reset_to_sink   = act_q[B_RST_SNK];
      end
      ACT_ERROR: act_req.force_error = 1'b1;
      ACT_SWAP:  act_req.vconn_swap  = 1'b1;
      default:   act_req = '0;
    endcase
  end

  // hold timer runs only while attached as sink with the hold bit set
  assign hold_run = act_q[B_SNK_HOLD] && fsm_sink_attached;

  tcc_timer #(
    .W     (TW),
    .LIMIT (HOLD_CYCLES)
  ) u_hold (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (hold_run),
    .done  (hold_done)
  );

  tcc_timer #(
    .W     (TW),
    .LIMIT (DEBOUNCE_CYCLES)
  ) u_deb (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (fsm_sink_attached && !vbus_above_threshold),
    .done  (deb_done)
  );

  // exit only after debounce, and never while the hold is running
  assign sink_exit_req = deb_done && !act_q[B_SNK_HOLD];

  // action bits: a write of one sets, done clears; set wins over clear
  always_comb
  begin
    act_d     = act_q;
    adv_lat_d = adv_lat_q;
    adv_app_d = adv_app_q;
    upd_d     = 1'b0;
    if (act_done.reset_to_source)
      act_d[B_RST_SRC] = 1'b0;
    if (act_done.reset_to_sink)
      act_d[B_RST_SNK] = 1'b0;
    if (act_done.force_error)
      act_d[B_FORCE_ERR] = 1'b0;
    if (act_done.vconn_swap)
      act_d[B_VCN_SWAP] = 1'b0;
    // hold ends when served, or when no sink session is there to hold
    if (hold_done || !fsm_sink_attached)
      act_d[B_SNK_HOLD] = 1'b0;
    // change waits for source operation and for any reset to finish
    if (act_q[B_CUR_CHG] && fsm_in_source && owner != ACT_RESET)
    begin
      act_d[B_CUR_CHG] = 1'b0;
      if (adv_lat_q != ADV_RESERVED)
      begin
        adv_app_d = adv_lat_q;
        upd_d     = 1'b1;
      end
    end
    if (wr_act)
    begin
      // zero writes leave pending actions alone
      act_d = act_d | (reg_wdata[5:0] & ACTION_MASK[5:0]);
      if (reg_wdata[B_CUR_CHG])
        adv_lat_d = cur_q[ADV_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_q     <= ACTION_RESET;
      adv_lat_q <= ADV_0A5;
      adv_app_q <= ADV_0A5;
      upd_q     <= 1'b0;
    end
    else
    begin
      act_q     <= act_d;
      adv_lat_q <= adv_lat_d;
      adv_app_q <= adv_app_d;
      upd_q     <= upd_d;
    end
  end

  // plain read/write registers and the read path
  always_comb
  begin
    en_d    = en_q;
    cur_d   = cur_q;
    rdata_d = rdata_q;
    if (reg_wr && reg_addr == ADDR_ENABLES)
      en_d = reg_wdata & ENABLES_MASK;
    if (reg_wr && reg_addr == ADDR_CURSEL)
      cur_d = reg_wdata & CURSEL_MASK;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_ACTION:  rdata_d = {2'b00, act_q};
        ADDR_ENABLES: rdata_d = en_q;
        ADDR_CURSEL:  rdata_d = cur_q;
        default:      rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      en_q    <= ENABLES_RESET;
      cur_q   <= CURSEL_RESET;
      rdata_q <= 8'h00;
    end
    else
    begin
      en_q    <= en_d;
      cur_q   <= cur_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  assign modes.vconn_auto_enable          = en_q[B_VCN_EN];
  assign modes.try_sink_enable            = en_q[B_TRY_SNK_EN];
  assign modes.debug_acc_source_detect_en = en_q[B_DBG_SRC_EN];
  assign modes.debug_acc_sink_detect_en   = en_q[B_DBG_SNK_EN];
  assign modes.audio_adapter_detect_en    = en_q[B_AUD_EN];
  assign modes.source_detect_en           = en_q[B_SRC_EN];
  assign modes.sink_detect_en             = en_q[B_SNK_EN];

  // vconn forced off while bit 7 is low, regardless of what the fsm wants
  assign vconn_on = en_q[B_VCN_EN] && fsm_vconn_want;

  assign adv_current_applied = adv_app_q;
  assign adv_current_update  = upd_q;

  assign pullup_current_override = cur_q[RP_LSB +: 3];
  assign pullup_forced           = cur_q[RP_LSB +: 3] != RP_BY_FSM;

  // low-power source current only matters in Unattached.SRC
  assign low_power_current_select = fsm_in_unattached_src
                                    ? cur_q[LP_LSB +: 2] : LP_NORMAL;
endmodule // tcc_cc_ctrl_regs

// ### logic/tcc_pkg.sv
// Purpose: constants and carriers for the cc control register bank
// Assumes: 100 MHz core clock, byte-wide register port from the serial core
// Notes:   offsets are the serial-port register addresses
// How it works
// - writing current-change request applies new advertised current in source; reads one until done
// - current-change request written outside source mode waits until source operation begins
// - force-error bit sends the fsm to ErrorRecovery, then self-clears; zero ignored
// - sink-attach hold clear: leave sink-attached after vbus low beyond loss debounce
// - sink-attach hold set: stay sink-attached at least 1.1 s without vbus, then self-clear; code times 1.1 s of sink attach from the hold write, not from vbus loss
// - vconn-swap bit asks the fsm to swap vconn roles, self-clears when done
// - source-reset bit jumps the fsm to Unattached.SRC, then self-clears
// - sink-reset bit jumps the fsm to Unattached.SNK, then self-clears
// - vconn auto-enable bit 7 low forces vconn off; high lets fsm control, resets high
// - try-sink enable bit 6 gates Try.SNK entry; resets low
// - debug accessory source detect enable bit 4; resets low
// - debug accessory sink detect enable bit 3; resets high
// - audio adapter detect enable bit 2; resets high
// - source detect enable bit 1; resets low
// - sink detect enable bit 0; resets high
// - advertised-current field latched on change-request write; applied only in source operation
// - advertised current codes 00 0.5A, 01 1.5A, 10 3.0A, 11 reserved
// - pull-up override 000 leaves fsm in control; other codes force fixed source
// - low-power select replaces 80uA in Unattached.SRC: 01 5.0uA, 10 1.0uA
package tcc_pkg;
  localparam logic [7:0] ADDR_ACTION  = 8'h20;
  localparam logic [7:0] ADDR_ENABLES = 8'h21;
  localparam logic [7:0] ADDR_CURSEL  = 8'h22;

  // action register bit positions
  localparam int B_CUR_CHG   = 5;
  localparam int B_FORCE_ERR = 4;
  localparam int B_SNK_HOLD  = 3;
  localparam int B_VCN_SWAP  = 2;
  localparam int B_RST_SRC   = 1;
  localparam int B_RST_SNK   = 0;
  localparam logic [5:0] ACTION_RESET = 6'h00;
  localparam logic [7:0] ACTION_MASK  = 8'h3F;

  // mode enable register
  localparam logic [7:0] ENABLES_RESET = 8'h8D;
  localparam logic [7:0] ENABLES_MASK  = 8'hDF;
  localparam int B_VCN_EN     = 7;
  localparam int B_TRY_SNK_EN = 6;
  localparam int B_DBG_SRC_EN = 4;
  localparam int B_DBG_SNK_EN = 3;
  localparam int B_AUD_EN     = 2;
  localparam int B_SRC_EN     = 1;
  localparam int B_SNK_EN     = 0;

  // current select register fields
  localparam int ADV_LSB = 5;
  localparam int LP_LSB  = 3;
  localparam int RP_LSB  = 0;
  localparam logic [7:0] CURSEL_RESET = 8'h00;
  localparam logic [7:0] CURSEL_MASK  = 8'h7F;

  localparam logic [1:0] ADV_0A5      = 2'h0;
  localparam logic [1:0] ADV_1A5      = 2'h1;
  localparam logic [1:0] ADV_3A0      = 2'h2;
  localparam logic [1:0] ADV_RESERVED = 2'h3;
  localparam logic [1:0] LP_NORMAL    = 2'h0;
  localparam logic [2:0] RP_BY_FSM    = 3'h0;

  // timing
  localparam int CLK_PERIOD_NS          = 10;
  localparam int SINK_HOLD_TIME_MS      = 1100;
  localparam int VBUS_LOSS_DEBOUNCE_US  = 10000;
  localparam int SINK_HOLD_CYCLES       = SINK_HOLD_TIME_MS * 1000000 / CLK_PERIOD_NS;
  localparam int VBUS_LOSS_CYCLES       = VBUS_LOSS_DEBOUNCE_US * 1000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic vconn_auto_enable;
    logic try_sink_enable;
    logic debug_acc_source_detect_en;
    logic debug_acc_sink_detect_en;
    logic audio_adapter_detect_en;
    logic source_detect_en;
    logic sink_detect_en;
  } tcc_modes_t;

  // requests held high until the matching done pulse, or until a higher-priority request takes over
  typedef struct packed {
    logic reset_to_source;
    logic reset_to_sink;
    logic force_error;
    logic vconn_swap;
  } tcc_req_t;

  typedef struct packed {
    logic reset_to_source;
    logic reset_to_sink;
    logic force_error;
    logic vconn_swap;
  } tcc_done_t;

  typedef enum logic [1:0] {
    ACT_IDLE  = 2'b00,
    ACT_RESET = 2'b01,
    ACT_ERROR = 2'b10,
    ACT_SWAP  = 2'b11
  } tcc_act_t;
endpackage

// ### logic/tcc_timer.sv
// Purpose: saturating up-counter that flags a run of LIMIT cycles
// Assumes: run is synchronous to clk
// Notes:   count restarts whenever run drops
module tcc_timer
  import tcc_pkg::*;
#(
  parameter int W     = 27,
  parameter int LIMIT = 100
)(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic run,
  output logic      done
);
  localparam logic [W-1:0] LIM = W'(LIMIT);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (!run)
      cnt_d = '0;
    else if (cnt_q != LIM)
      cnt_d = cnt_q + W'(1);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign done = run && (cnt_q == LIM);
endmodule // tcc_timer

// ### testbench/tcc_cc_ctrl_regs_bench.sv
// Purpose: self-checking bench for the cc control register bank
// Assumes: shortened hold and debounce timers
// Notes:   fsm side is tcc_fsm_model
module tcc_cc_ctrl_regs_bench
  import tcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DEB = 8;
  localparam int HOLD = 20;
  logic clk, rst_n, reg_wr, reg_rd, fsm_in_source, fsm_in_unattached_src;
  logic fsm_sink_attached, fsm_vconn_want, vbus_above_threshold;
  logic sink_exit_req, vconn_on, adv_current_update, pullup_forced;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rd_v;
  logic [3:0] dly;
  logic [2:0] pullup_current_override;
  logic [1:0] adv_current_applied, low_power_current_select;
  tcc_done_t  act_done;
  tcc_req_t   act_req;
  tcc_modes_t modes;
  int num_errors, n_tests, cyc;
  tcc_cc_ctrl_regs #(.HOLD_CYCLES(HOLD), .DEBOUNCE_CYCLES(DEB)) u_tcc_cc_ctrl_regs (.*);
  tcc_fsm_model u_tcc_fsm_model (.*);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    if (num_errors == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      num_errors++;
    end
  endtask
  // callers sit at a falling edge
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    // idle cycle: strobe never toggles twice in one step
    @(negedge clk);
  endtask
  task automatic rd(logic [7:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    rd_v = reg_rdata;
    @(negedge clk);
  endtask
  task automatic wait_req(logic [3:0] e);
    for (int i = 0; i < 40 && act_req !== e; i++) @(negedge clk);
    chk("act_req", {4'h0, e}, {4'h0, act_req});
  endtask
  task automatic t_enables();
    rd(8'h21);
    chk("en_rst", 8'h8D, rd_v);
    rd(8'h22);
    chk("cur_rst", 8'h00, rd_v);
    rd(8'h3F);
    chk("unmapped", 8'h00, rd_v);
    wr(8'h21, 8'hFF);
    rd(8'h21);
    chk("en_all", 8'hDF, rd_v);
    wr(8'h21, 8'h0D);
    chk("vconn_off", 8'h00, {7'h0, vconn_on});
    wr(8'h21, 8'h8D);
    chk("vconn_auto", 8'h01, {7'h0, vconn_on});
    fsm_vconn_want = 1'b0;
    @(negedge clk);
    chk("vconn_fsm_off", 8'h00, {7'h0, vconn_on});
    fsm_vconn_want = 1'b1;
  endtask
  task automatic t_actions();
    dly = 4'd9;
    wr(8'h20, 8'h02);
    chk("src_req", 8'h08, {4'h0, act_req});
    rd(8'h20);
    chk("src_pend", 8'h02, rd_v);
    wait_req(4'h0);
    dly = 4'd0;
    wr(8'h20, 8'h17);
    chk("resets", 8'h0C, {4'h0, act_req});
    wait_req(4'h2);
    wait_req(4'h1);
    wait_req(4'h0);
    rd(8'h20);
    chk("act_clr", 8'h00, rd_v);
  endtask
  task automatic t_cur_change();
    wr(8'h22, 8'h20);
    wr(8'h20, 8'h20);
    wr(8'h22, 8'h40);
    rd(8'h20);
    chk("cur_pend", 8'h20, rd_v);
    fsm_in_source = 1'b1;
    for (int i = 0; i < 20 && adv_current_update !== 1'b1; i++) @(negedge clk);
    chk("applied", 8'h01, {6'h0, adv_current_applied});
    rd(8'h20);
    chk("cur_done", 8'h00, rd_v);
    wr(8'h22, 8'h60);
    wr(8'h20, 8'h20);
    rd(8'h20);
    chk("rsv_clr", 8'h00, rd_v);
    chk("rsv_keep", 8'h01, {6'h0, adv_current_applied});
  endtask
  task automatic t_low_power();
    wr(8'h22, 8'h0D);
    chk("lp_off", 8'h00, {6'h0, low_power_current_select});
    fsm_in_unattached_src = 1'b1;
    @(negedge clk);
    chk("lp_on", 8'h01, {6'h0, low_power_current_select});
    chk("rp_forced", 8'h0D, {4'h0, pullup_forced, pullup_current_override});
    wr(8'h22, 8'h00);
    chk("rp_fsm", 8'h00, {4'h0, pullup_forced, pullup_current_override});
  endtask
  task automatic t_sink_hold();
    fsm_sink_attached = 1'b1;
    wr(8'h20, 8'h08);
    vbus_above_threshold = 1'b0;
    repeat (DEB + 4) @(negedge clk);
    chk("held", 8'h00, {7'h0, sink_exit_req});
    rd(8'h20);
    chk("hold_set", 8'h08, rd_v);
    repeat (HOLD) @(negedge clk);
    rd(8'h20);
    chk("hold_clr", 8'h00, rd_v);
    repeat (DEB + 2) @(negedge clk);
    chk("exit", 8'h01, {7'h0, sink_exit_req});
  endtask
  initial
  begin
    {reg_wr, reg_rd, fsm_in_source, fsm_in_unattached_src, fsm_sink_attached} = '0;
    {reg_addr, reg_wdata, dly, rst_n, fsm_vconn_want} = '0;
    fsm_vconn_want = 1'b1;
    vbus_above_threshold = 1'b1;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_enables();
    t_actions();
    t_cur_change();
    t_low_power();
    t_sink_hold();
    summarize();
  end
endmodule // tcc_cc_ctrl_regs_bench

// ### testbench/tcc_cc_ctrl_regs_monitor.sv
// Purpose: port-level checks of the cc control register bank
// Assumes: one clock domain, async active-low reset
// Notes:   bound into every instance of the top module
module tcc_cc_ctrl_regs_monitor
  import tcc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       fsm_in_source,
  input wire logic       fsm_in_unattached_src,
  input wire logic       fsm_sink_attached,
  input wire logic       fsm_vconn_want,
  input wire logic       vbus_above_threshold,
  input tcc_done_t       act_done,
  input tcc_req_t        act_req,
  input tcc_modes_t      modes,
  input wire logic       sink_exit_req,
  input wire logic       vconn_on,
  input wire logic       adv_current_update,
  input wire logic [2:0] pullup_current_override,
  input wire logic       pullup_forced,
  input wire logic [1:0] low_power_current_select
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_vconn; vconn_on == (modes.vconn_auto_enable && fsm_vconn_want); endproperty
  a_vconn: assert property (p_vconn) else $error("vconn gate");
  property p_rd; reg_rd && !reg_wr && reg_addr == ADDR_ENABLES |=>
    reg_rdata == {modes[6:5], 1'b0, modes[4:0]}; endproperty
  a_rd: assert property (p_rd) else $error("enables readback");
  property p_src_set; reg_wr && reg_addr == ADDR_ACTION && reg_wdata[B_RST_SRC] |=>
    act_req.reset_to_source; endproperty
  a_src_set: assert property (p_src_set) else $error("src reset req");
  property p_src_hold; act_req.reset_to_source && !act_done.reset_to_source |=>
    act_req.reset_to_source; endproperty
  a_src_hold: assert property (p_src_hold) else $error("src req dropped");
  property p_snk_clr; act_done.reset_to_sink && !reg_wr |=> !act_req.reset_to_sink; endproperty
  a_snk_clr: assert property (p_snk_clr) else $error("snk req stuck");
  property p_err; act_req.force_error |-> !(act_req.reset_to_source || act_req.reset_to_sink);
  endproperty
  a_err: assert property (p_err) else $error("error over reset");
  property p_swap; act_req.vconn_swap |-> !(act_req.force_error || act_req.reset_to_sink
    || act_req.reset_to_source); endproperty
  a_swap: assert property (p_swap) else $error("swap over higher");
  property p_exit; sink_exit_req |-> fsm_sink_attached && !$past(vbus_above_threshold, 4);
  endproperty
  a_exit: assert property (p_exit) else $error("early sink exit");
  property p_lp; low_power_current_select != 2'h0 |-> fsm_in_unattached_src; endproperty
  a_lp: assert property (p_lp) else $error("low power leak");
  property p_pull; pullup_forced == (pullup_current_override != 3'h0); endproperty
  a_pull: assert property (p_pull) else $error("pullup forced");
  property p_upd; adv_current_update |-> $past(fsm_in_source); endproperty
  a_upd: assert property (p_upd) else $error("update outside source");
  c_src: cover property (act_done.reset_to_source);
  c_upd: cover property (adv_current_update);
  c_exit: cover property (sink_exit_req);
endmodule // tcc_cc_ctrl_regs_monitor

bind tcc_cc_ctrl_regs tcc_cc_ctrl_regs_monitor u_tcc_cc_ctrl_regs_monitor (.*);

// ### testbench/tcc_fsm_model.sv
// Purpose: behavioural cc fsm answering action requests
// Assumes: requests are levels held until done
// Notes:   dly sets the cycles the fsm takes per action
module tcc_fsm_model
  import tcc_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_n,
  input tcc_req_t        act_req,
  input wire logic [3:0] dly,
  output tcc_done_t      act_done
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_q;
  // finishes all shown requests at once; the bank shows only the top ones
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= '0;
      act_done <= '0;
    end
    else if (act_req == '0 || act_done != '0)
    begin
      cnt_q <= '0;
      act_done <= '0;
    end
    else if (cnt_q == dly)
      act_done <= act_req;
    else
      cnt_q <= cnt_q + 4'h1;
  end
endmodule // tcc_fsm_model
